// file: rtl/sfi_core.sv
// Serial flash interface state machine, link side and system side
module sfi_core #(
    parameter int         PUW_CYCLES = sfi_pkg::PUW_CYCLES,
    parameter logic [4:0] DUAL_IO_LAT = sfi_pkg::DIO_LAT
) (
    input  wire logic        sys_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        ce_in,
    input  wire logic        quad_enable_bit_in,
    input  wire logic [3:0]  quad_latency_field_in,
    input  wire logic [7:0]  rd_byte_in,
    input  wire logic        link_clk_in,
    input  wire logic        cs_n_in,
    input  wire logic        lane_zero_in,
    input  wire logic        lane_one_in,
    input  wire logic        lane_two_in,
    input  wire logic        lane_three_in,
    output logic             lane_zero_out,
    output logic             lane_one_out,
    output logic             lane_two_out,
    output logic             lane_three_out,
    output logic             lane_zero_oe_out,
    output logic             lane_one_oe_out,
    output logic             lane_two_oe_out,
    output logic             lane_three_oe_out,
    output logic             cmd_strobe_out,
    output logic [7:0]       cmd_opcode_out,
    output logic [23:0]      cmd_addr_out,
    output logic [7:0]       cmd_data_out,
    output logic             cmd_wp_out,
    output logic             cmd_refused_out,
    output logic             cmd_complete_out,
    output logic             write_ready_out
);
    localparam int PW = $clog2(PUW_CYCLES + 1);
    localparam logic [PW-1:0] PUW_LAST = PW'(PUW_CYCLES - 1);

    // Link state cleared by chip select; held results survive the frame
    typedef struct packed {
        sfi_pkg::sfi_state_t st;
        logic [4:0]          cnt;
        logic [4:0]          lat;
    } sfi_rise_t;

    typedef struct packed {
        logic [1:0]  ce_s;
        logic [1:0]  qe_s;
        logic [1:0]  wr_s;
        logic [3:0]  lat_s1;
        logic [3:0]  lat_s2;
        logic [7:0]  rd_s1;
        logic [7:0]  rd_s2;
        logic [7:0]  op;
        logic [31:0] addr;
        logic [7:0]  data;
        logic        wp;
        logic        refused;
        logic        complete;
    } sfi_keep_t;

    typedef struct packed {
        logic [2:0] ptr;
        logic [3:0] o;
        logic [3:0] oe;
    } sfi_fall_t;

    typedef struct packed {
        logic [2:0]    cs_s;
        logic          cs_lvl;
        logic [PW-1:0] puw_cnt;
        logic          wr_ready;
        logic          strobe;
        logic [7:0]    op;
        logic [23:0]   addr;
        logic [7:0]    data;
        logic          wp;
        logic          refused;
        logic          complete;
    } sfi_sys_t;

    localparam sfi_rise_t RISE_RST = '{st: sfi_pkg::ST_STANDBY,
                                       cnt: 5'h00, lat: 5'h00};
    localparam sfi_sys_t SYS_RST = '{cs_s: 3'h7, cs_lvl: 1'b1,
                                     default: '0};

    sfi_rise_t r;
    sfi_rise_t next_r;
    sfi_keep_t k;
    sfi_keep_t next_k;
    sfi_fall_t n;
    sfi_fall_t next_n;
    sfi_sys_t  s;
    sfi_sys_t  next_s;
    logic      link_rst_n;
    logic      hold;
    logic      act;
    logic [7:0] op_full;
    logic [7:0] sh;

    assign link_rst_n = rst_n_in & ~cs_n_in;
    assign hold = ~k.qe_s[1] & ~lane_three_in;
    // Select high masks the edge, so a free-running clock between frames
    // cannot clear the held command before the system side has taken it
    assign act = k.ce_s[1] & ~hold & ~cs_n_in;
    assign op_full = {k.op[6:0], lane_zero_in};
    assign sh = k.rd_s2 << n.ptr;

    // Rising edge: every input bit is taken here; the pause level on lane three is also sampled at the fall
    always_comb begin
        next_r = r;
        next_k = k;
        next_k.ce_s = {k.ce_s[0], ce_in};
        next_k.qe_s = {k.qe_s[0], quad_enable_bit_in};
        next_k.wr_s = {k.wr_s[0], s.wr_ready};
        next_k.lat_s1 = quad_latency_field_in;
        next_k.lat_s2 = k.lat_s1;
        next_k.rd_s1 = rd_byte_in;
        next_k.rd_s2 = k.rd_s1;
        if (act) begin
            case (r.st)
                sfi_pkg::ST_STANDBY: begin
                    next_k.op = {7'h00, lane_zero_in};
                    next_k.addr = '0;
                    next_k.data = '0;
                    next_k.wp = 1'b0;
                    next_k.refused = 1'b0;
                    next_k.complete = 1'b0;
                    next_r.cnt = 5'h01;
                    next_r.st = sfi_pkg::ST_INSTR;
                end
                sfi_pkg::ST_INSTR: begin
                    next_k.op = op_full;
                    next_r.cnt = r.cnt + 5'h01;
                    if (r.cnt == sfi_pkg::INSTR_LAST) begin
                        next_r.cnt = 5'h00;
                        next_r.st = sfi_pkg::ST_IGNORE;
                        case (op_full)
                            sfi_pkg::OP_WREN: begin
                                next_k.complete = 1'b1;
                                next_k.refused = ~k.wr_s[1];
                            end
                            sfi_pkg::OP_WRSR: begin
                                next_k.wp = ~k.qe_s[1] & ~lane_two_in;
                                next_k.refused = ~k.wr_s[1];
                                if (k.wr_s[1]) begin
                                    next_r.st = sfi_pkg::ST_SIN;
                                end
                            end
                            sfi_pkg::OP_READ,
                            sfi_pkg::OP_FAST,
                            sfi_pkg::OP_DOR: begin
                                next_r.st = sfi_pkg::ST_SIN;
                            end
                            sfi_pkg::OP_QOR: begin
                                if (k.qe_s[1]) begin
                                    next_r.st = sfi_pkg::ST_SIN;
                                end
                            end
                            sfi_pkg::OP_DIOR: begin
                                next_r.st = sfi_pkg::ST_DIN;
                            end
                            sfi_pkg::OP_QIOR: begin
                                if (k.qe_s[1]) begin
                                    next_r.st = sfi_pkg::ST_QIN;
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                sfi_pkg::ST_SIN: begin
                    next_r.cnt = r.cnt + 5'h01;
                    if (k.op == sfi_pkg::OP_WRSR) begin
                        next_k.data = {k.data[6:0], lane_zero_in};
                        if (r.cnt == sfi_pkg::DATA_LAST) begin
                            next_k.complete = 1'b1;
                            next_r.st = sfi_pkg::ST_IGNORE;
                        end
                    end else begin
                        next_k.addr = {k.addr[30:0], lane_zero_in};
                        if (r.cnt == sfi_pkg::ADDR_LAST) begin
                            next_r.st = sfi_pkg::ST_SLAT;
                            case (k.op)
                                sfi_pkg::OP_READ:
                                    next_r.st = sfi_pkg::ST_SOUT;
                                sfi_pkg::OP_FAST:
                                    next_r.lat = sfi_pkg::FAST_LAT;
                                sfi_pkg::OP_DOR:
                                    next_r.lat = sfi_pkg::DOR_LAT;
                                default:
                                    next_r.lat = sfi_pkg::QOR_LAT;
                            endcase
                        end
                    end
                end
                sfi_pkg::ST_DIN: begin
                    next_k.addr = {k.addr[29:0], lane_one_in,
                                   lane_zero_in};
                    next_r.cnt = r.cnt + 5'h01;
                    if (r.cnt == sfi_pkg::DIN_LAST) begin
                        next_r.lat = DUAL_IO_LAT;
                        next_r.st = (DUAL_IO_LAT == 5'h00) ?
                                    sfi_pkg::ST_DOUT : sfi_pkg::ST_DLAT;
                    end
                end
                sfi_pkg::ST_QIN: begin
                    next_k.addr = {k.addr[27:0], lane_three_in,
                                   lane_two_in, lane_one_in, lane_zero_in};
                    next_r.cnt = r.cnt + 5'h01;
                    if (r.cnt == sfi_pkg::QIN_LAST) begin
                        next_r.lat = {1'b0, k.lat_s2};
                        next_r.st = (k.lat_s2 == 4'h0) ?
                                    sfi_pkg::ST_QOUT : sfi_pkg::ST_QLAT;
                    end
                end
                sfi_pkg::ST_SLAT,
                sfi_pkg::ST_DLAT,
                sfi_pkg::ST_QLAT: begin
                    next_r.lat = r.lat - 5'h01;
                    if (r.lat == 5'h01) begin
                        if (r.st == sfi_pkg::ST_DLAT ||
                            k.op == sfi_pkg::OP_DOR) begin
                            next_r.st = sfi_pkg::ST_DOUT;
                        end else if (r.st == sfi_pkg::ST_QLAT ||
                                     k.op == sfi_pkg::OP_QOR) begin
                            next_r.st = sfi_pkg::ST_QOUT;
                        end else begin
                            next_r.st = sfi_pkg::ST_SOUT;
                        end
                    end
                end
                sfi_pkg::ST_SOUT,
                sfi_pkg::ST_DOUT,
                sfi_pkg::ST_QOUT: begin
                end
                sfi_pkg::ST_IGNORE: begin
                    // A clock past the byte boundary voids the command
                    next_k.complete = 1'b0;
                end
                default: begin
                    next_r.st = sfi_pkg::ST_IGNORE;
                end
            endcase
        end
    end

    // Falling edge: outputs launch here so they are settled for the host
    always_comb begin
        next_n = n;
        if (k.ce_s[1]) begin
            next_n.oe = sfi_pkg::OE_NONE;
            if (!hold) begin
                case (r.st)
                    sfi_pkg::ST_SOUT: begin
                        next_n.oe = sfi_pkg::OE_SGL;
                        next_n.o = {2'b00, sh[7], 1'b0};
                        next_n.ptr = n.ptr + 3'h1;
                    end
                    sfi_pkg::ST_DOUT: begin
                        next_n.oe = sfi_pkg::OE_DUAL;
                        next_n.o = {2'b00, sh[7:6]};
                        next_n.ptr = n.ptr + 3'h2;
                    end
                    sfi_pkg::ST_QOUT: begin
                        next_n.oe = sfi_pkg::OE_QUAD;
                        next_n.o = sh[7:4];
                        next_n.ptr = n.ptr + 3'h4;
                    end
                    default: begin
                        next_n.o = 4'h0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge link_clk_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            r <= RISE_RST;
        end else begin
            r <= next_r;
        end
    end

    always_ff @(posedge link_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            k <= '0;
        end else begin
            k <= next_k;
        end
    end

    always_ff @(negedge link_clk_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            n <= '0;
        end else begin
            n <= next_n;
        end
    end

    // System side: results are read only after chip select has risen,
    // when select masks any link clock edges and the held words cannot move
    always_comb begin
        next_s = s;
        next_s.strobe = 1'b0;
        if (ce_in) begin
            next_s.cs_s = {s.cs_s[1:0], cs_n_in};
            if (s.cs_s[1] == s.cs_s[2]) begin
                next_s.cs_lvl = s.cs_s[2];
                if (s.cs_s[2] && !s.cs_lvl) begin
                    next_s.strobe = 1'b1;
                    next_s.op = k.op;
                    next_s.addr = (k.op == sfi_pkg::OP_DIOR ||
                                   k.op == sfi_pkg::OP_QIOR) ?
                                  k.addr[31:8] : k.addr[23:0];
                    next_s.data = k.data;
                    next_s.wp = k.wp;
                    next_s.refused = k.refused;
                    next_s.complete = k.complete;
                end
            end
            if (!s.wr_ready) begin
                if (s.puw_cnt == PUW_LAST) begin
                    next_s.wr_ready = 1'b1;
                end else begin
                    next_s.puw_cnt = s.puw_cnt + PW'(1);
                end
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s <= SYS_RST;
        end else begin
            s <= next_s;
        end
    end

    assign lane_zero_out = n.o[0];
    assign lane_one_out = n.o[1];
    assign lane_two_out = n.o[2];
    assign lane_three_out = n.o[3];
    assign lane_zero_oe_out = n.oe[0];
    assign lane_one_oe_out = n.oe[1];
    assign lane_two_oe_out = n.oe[2];
    assign lane_three_oe_out = n.oe[3];
    assign cmd_strobe_out = s.strobe;
    assign cmd_opcode_out = s.op;
    assign cmd_addr_out = s.addr;
    assign cmd_data_out = s.data;
    assign cmd_wp_out = s.wp;
    assign cmd_refused_out = s.refused;
    assign cmd_complete_out = s.complete;
    assign write_ready_out = s.wr_ready;

    property p_standby_quiet;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        cs_n_in |-> (n.oe == sfi_pkg::OE_NONE);
    endproperty
    a_standby_quiet: assert property (p_standby_quiet)
        else $error("lanes driven while deselected");

    property p_instr_start;
        @(posedge link_clk_in) disable iff (!link_rst_n)
        (r.st == sfi_pkg::ST_STANDBY && act) |=>
            (r.st == sfi_pkg::ST_INSTR && r.cnt == 5'h01);
    endproperty
    a_instr_start: assert property (p_instr_start)
        else $error("instruction capture not entered");

    property p_instr_shift;
        @(posedge link_clk_in) disable iff (!link_rst_n)
        (r.st == sfi_pkg::ST_INSTR && act) |=>
            (k.op == {$past(k.op[6:0]), $past(lane_zero_in)});
    endproperty
    a_instr_shift: assert property (p_instr_shift)
        else $error("instruction bit not shifted msb first");

    property p_pause_freeze;
        @(posedge link_clk_in) disable iff (!link_rst_n)
        hold |=> ($stable(r.st) && $stable(r.cnt));
    endproperty
    a_pause_freeze: assert property (p_pause_freeze)
        else $error("state moved during pause");

    property p_sin_quiet;
        @(posedge link_clk_in) disable iff (!link_rst_n)
        (r.st == sfi_pkg::ST_SIN) |-> !n.oe[1];
    endproperty
    a_sin_quiet: assert property (p_sin_quiet)
        else $error("serial output driven in input cycle");

    property p_read_out;
        @(posedge link_clk_in) disable iff (!link_rst_n)
        (r.st == sfi_pkg::ST_SIN && act && k.op == sfi_pkg::OP_READ &&
         r.cnt == sfi_pkg::ADDR_LAST) |=> (r.st == sfi_pkg::ST_SOUT);
    endproperty
    a_read_out: assert property (p_read_out)
        else $error("read did not reach single output");

    property p_lat_quiet;
        @(posedge link_clk_in) disable iff (!link_rst_n)
        (r.st inside {sfi_pkg::ST_SLAT, sfi_pkg::ST_DLAT,
                      sfi_pkg::ST_QLAT}) |-> (n.oe == sfi_pkg::OE_NONE);
    endproperty
    a_lat_quiet: assert property (p_lat_quiet)
        else $error("lanes driven during latency");

    property p_dual_capture;
        @(posedge link_clk_in) disable iff (!link_rst_n)
        (r.st == sfi_pkg::ST_DIN && act) |=>
            (k.addr[1:0] == $past({lane_one_in, lane_zero_in}));
    endproperty
    a_dual_capture: assert property (p_dual_capture)
        else $error("dual address bits not captured");

    property p_quad_first;
        @(posedge link_clk_in) disable iff (!link_rst_n)
        (r.st == sfi_pkg::ST_QLAT && r.lat == 5'h01 && act) |=>
            (r.st == sfi_pkg::ST_QOUT && n.oe == sfi_pkg::OE_QUAD);
    endproperty
    a_quad_first: assert property (p_quad_first)
        else $error("quad data not driven after latency");

    property p_quad_lat;
        @(posedge link_clk_in) disable iff (!link_rst_n)
        (r.st == sfi_pkg::ST_QIN && act && r.cnt == sfi_pkg::QIN_LAST &&
         k.lat_s2 != 4'h0) |=> (r.lat == {1'b0, $past(k.lat_s2)});
    endproperty
    a_quad_lat: assert property (p_quad_lat)
        else $error("quad latency not from field");

    property p_dual_lanes;
        @(posedge link_clk_in) disable iff (!link_rst_n)
        (r.st == sfi_pkg::ST_DOUT && n.oe != sfi_pkg::OE_NONE) |->
            (n.oe == sfi_pkg::OE_DUAL);
    endproperty
    a_dual_lanes: assert property (p_dual_lanes)
        else $error("dual output on wrong lanes");

    property p_write_refused;
        @(posedge sys_clk_in) disable iff (!rst_n_in)
        (cmd_strobe_out && !write_ready_out &&
         cmd_opcode_out == sfi_pkg::OP_WREN) |-> cmd_refused_out;
    endproperty
    a_write_refused: assert property (p_write_refused)
        else $error("write accepted during power-up delay");

    property p_select_ignore;
        @(posedge link_clk_in) disable iff (!rst_n_in)
        cs_n_in |=> ($stable(k.op) && $stable(k.addr) && $stable(k.data));
    endproperty
    a_select_ignore: assert property (p_select_ignore)
        else $error("held command changed while deselected");
endmodule : sfi_core

// file: rtl/sfi_pkg.sv
// Constants, opcodes and state encoding for the serial flash interface
package sfi_pkg;
    // Power-up write delay: plain default, not a characterised figure
    localparam int PUW_TIME_US = 1000;
    localparam int CLK_MHZ     = 100;
    localparam int PUW_CYCLES  = PUW_TIME_US * CLK_MHZ;

    localparam logic [4:0] INSTR_LAST = 5'h07;
    localparam logic [4:0] ADDR_LAST  = 5'h17;
    localparam logic [4:0] DATA_LAST  = 5'h07;
    localparam logic [4:0] DIN_LAST   = 5'h0f;
    localparam logic [4:0] QIN_LAST   = 5'h07;

    // Latency cycles fixed by the command; DIO_LAT is only the default of DUAL_IO_LAT
    localparam logic [4:0] FAST_LAT = 5'h08;
    localparam logic [4:0] DOR_LAT  = 5'h08;
    localparam logic [4:0] QOR_LAT  = 5'h08;
    localparam logic [4:0] DIO_LAT  = 5'h04;

    // Opcode values are arbitrary
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_FAST = 8'h0b;
    localparam logic [7:0] OP_DOR  = 8'h3b;
    localparam logic [7:0] OP_QOR  = 8'h6b;
    localparam logic [7:0] OP_DIOR = 8'hbb;
    localparam logic [7:0] OP_QIOR = 8'heb;

    localparam logic [3:0] OE_NONE = 4'h0;
    localparam logic [3:0] OE_SGL  = 4'h2;
    localparam logic [3:0] OE_DUAL = 4'h3;
    localparam logic [3:0] OE_QUAD = 4'hf;

    typedef enum logic [11:0] {
        ST_STANDBY = 12'h001,
        ST_INSTR   = 12'h002,
        ST_SIN     = 12'h004,
        ST_DIN     = 12'h008,
        ST_QIN     = 12'h010,
        ST_SLAT    = 12'h020,
        ST_DLAT    = 12'h040,
        ST_QLAT    = 12'h080,
        ST_SOUT    = 12'h100,
        ST_DOUT    = 12'h200,
        ST_QOUT    = 12'h400,
        ST_IGNORE  = 12'h800
    } sfi_state_t;
endpackage : sfi_pkg

// file: dv/sfi_host_model.sv
// Host controller model: chip select, serial clock and lane drive
module sfi_host_model (
    output logic            clk_out,
    output logic            cs_n_out,
    output logic [3:0]      lane_out,
    input  wire logic [3:0] lane_in
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        clk_out  = 1'b0;
        cs_n_out = 1'b1;
        lane_out = 4'hc;
    end
    // Released lanes flip each cycle so a stale level never passes;
    // lanes move just after the fall so the pause level is settled there
    task automatic cycle(input logic [3:0] v, input logic [3:0] drv,
                         output logic [3:0] rd);
        #1 lane_out = (v & drv) | (~lane_out & ~drv);
        #15 clk_out = 1'b1;
        rd = lane_in;
        #16 clk_out = 1'b0;
    endtask : cycle
    task automatic sel(input logic v);
        cs_n_out = v;
    endtask : sel
endmodule : sfi_host_model

// file: dv/tb.sv
// Self-checking bench for the serial flash interface state machine
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int PUW = 200;
    logic        sys_clk_in;
    logic        rst_n_in;
    logic        qe;
    logic [3:0]  lat;
    logic [7:0]  rbyte;
    logic        lclk;
    logic        cs_n;
    logic [3:0]  hl;
    logic [3:0]  dout;
    logic [3:0]  doe;
    logic [3:0]  lane;
    logic [3:0]  rd;
    logic        stb;
    logic [7:0]  opc;
    logic [23:0] adr;
    logic [7:0]  dat;
    logic        wp;
    logic        refd;
    logic        cmpl;
    logic        wrdy;
    int          error_cnt;
    int          n_tests;
    logic [3:0]  oe_seen;
    assign lane = (doe & dout) | (~doe & hl);
    // Enables as the host sees them at its rising edge, never mid-update
    always @(posedge lclk) oe_seen <= doe;
    sfi_host_model sfi_host_model_i (.clk_out(lclk), .cs_n_out(cs_n),
        .lane_out(hl), .lane_in(lane));
    sfi_core #(.PUW_CYCLES(PUW)) sfi_core_i (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
        .quad_enable_bit_in(qe), .quad_latency_field_in(lat),
        .rd_byte_in(rbyte), .link_clk_in(lclk), .cs_n_in(cs_n),
        .lane_zero_in(lane[0]), .lane_one_in(lane[1]),
        .lane_two_in(lane[2]), .lane_three_in(lane[3]),
        .lane_zero_out(dout[0]), .lane_one_out(dout[1]),
        .lane_two_out(dout[2]), .lane_three_out(dout[3]),
        .lane_zero_oe_out(doe[0]), .lane_one_oe_out(doe[1]),
        .lane_two_oe_out(doe[2]), .lane_three_oe_out(doe[3]),
        .cmd_strobe_out(stb), .cmd_opcode_out(opc), .cmd_addr_out(adr),
        .cmd_data_out(dat), .cmd_wp_out(wp), .cmd_refused_out(refd),
        .cmd_complete_out(cmpl), .write_ready_out(wrdy));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic stop_test;
        if (error_cnt == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test
    task automatic cyc(input logic [3:0] v, input logic [3:0] m);
        sfi_host_model_i.cycle(v, m, rd);
    endtask : cyc
    // Link edges with select high let the synced settings settle
    task automatic idle;
        repeat (4) begin
            cyc(4'hc, 4'hd);
            chk(oe_seen, 4'h0);
        end
    endtask : idle
    task automatic op(input logic [7:0] o, input logic wpl);
        sfi_host_model_i.sel(1'b0);
        for (int i = 7; i >= 0; i--) begin
            cyc({1'b1, ~wpl, 1'b0, o[i]}, 4'hd);
            chk(oe_seen, 4'h0);
        end
    endtask : op
    task automatic fin;
        int n;
        sfi_host_model_i.sel(1'b1);
        #1 chk(doe, 4'h0);
        n = 0;
        while (stb !== 1'b1 && n < 20) begin
            @(posedge sys_clk_in);
            #1 n++;
        end
        chk(stb, 1'b1);
        repeat (8) @(posedge sys_clk_in);
    endtask : fin
    task automatic cfg(input logic q, input logic [3:0] l);
        @(posedge sys_clk_in);
        #1 qe = q;
        lat = l;
        idle();
    endtask : cfg
    task automatic t_write;
        idle();
        chk(wrdy, 1'b0);
        op(sfi_pkg::OP_WREN, 1'b0);
        fin();
        chk(refd, 1'b1);
        for (int n = 0; n < 400 && wrdy !== 1'b1; n++)
            @(posedge sys_clk_in);
        chk(wrdy, 1'b1);
        idle();
        op(sfi_pkg::OP_WREN, 1'b0);
        fin();
        chk({refd, cmpl}, 2'b01);
        op(sfi_pkg::OP_WRSR, 1'b1);
        for (int i = 7; i >= 0; i--) cyc({3'b110, 1'(8'ha5 >> i)}, 4'hd);
        fin();
        chk({wp, cmpl, dat}, {2'b11, 8'ha5});
        // Protect low only after the opcode, and one bit too many
        op(sfi_pkg::OP_WRSR, 1'b0);
        for (int i = 8; i >= 0; i--) cyc({3'b100, 1'(9'h14b >> i)}, 4'hd);
        fin();
        chk({wp, cmpl}, 2'b00);
    endtask : t_write
    task automatic rdf(input logic [7:0] o, input int aw, input int lc,
                       input int ow, input logic [3:0] eoe, input bit pz);
        logic [31:0] a;
        logic [3:0]  m;
        a = {24'h123456, 8'h00};
        m = (ow == 4) ? 4'h0 : 4'hc;
        op(o, 1'b0);
        for (int k = 0; k < (aw == 1 ? 24 : 32) / aw; k++) begin
            if (pz && k == 10) repeat (2) cyc({3'b0, ~a[31 - k]}, 4'h9);
            cyc(4'((a << (k * aw)) >> (32 - aw)) | (aw == 4 ? 4'h0 : 4'hc),
                aw == 1 ? 4'hd : 4'hf);
            chk(oe_seen, 4'h0);
        end
        for (int k = 0; k < lc; k++) begin
            cyc(4'hc, m);
            chk(oe_seen, 4'h0);
        end
        for (int k = 0; k < 16 / ow; k++) begin
            cyc(4'hc, m);
            if (eoe != 4'h0) chk(ow == 1 ? 4'(rd[1]) : rd & eoe,
                4'(({rbyte, rbyte} << (k * ow)) >> (16 - ow)));
            chk(oe_seen, eoe);
        end
        fin();
        chk(opc, o);
        if (eoe != 4'h0) chk(adr, 24'h123456);
    endtask : rdf
    initial begin
        sys_clk_in = 1'b0;
        forever #5 sys_clk_in = ~sys_clk_in;
    end
    initial begin
        #100us;
        error_cnt++;
        stop_test();
    end
    initial begin
        rst_n_in = 1'b0;
        qe = 1'b0;
        lat = 4'h0;
        rbyte = 8'h96;
        error_cnt = 0;
        n_tests = 0;
        repeat (16) @(posedge sys_clk_in);
        #1 rst_n_in = 1'b1;
        t_write();
        rdf(sfi_pkg::OP_READ, 1, 0, 1, 4'h2, 1'b1);
        rdf(sfi_pkg::OP_FAST, 1, sfi_pkg::FAST_LAT, 1, 4'h2, 1'b0);
        rdf(sfi_pkg::OP_DOR, 1, sfi_pkg::DOR_LAT, 2, 4'h3, 1'b0);
        rdf(sfi_pkg::OP_DIOR, 2, sfi_pkg::DIO_LAT, 2, 4'h3, 1'b0);
        rdf(sfi_pkg::OP_QOR, 1, sfi_pkg::QOR_LAT, 4, 4'h0, 1'b0);
        cfg(1'b1, 4'h2);
        rdf(sfi_pkg::OP_QOR, 1, sfi_pkg::QOR_LAT, 4, 4'hf, 1'b0);
        rdf(sfi_pkg::OP_QIOR, 4, 2, 4, 4'hf, 1'b0);
        cfg(1'b1, 4'h0);
        rdf(sfi_pkg::OP_QIOR, 4, 0, 4, 4'hf, 1'b0);
        stop_test();
    end
endmodule : tb
